// ===== hdl/ipsc_access_chk.sv
// Storage reference checker: protection, low storage and alignment.
// Assumes the reference fields are stable while ref_valid_i is high.
`timescale 1ns/1ps
`default_nettype none
module ipsc_access_chk
  import ipsc_pkg::*;
(
  input wire logic ref_valid_i,
  input wire logic [ADDR_W-1:0] ref_addr_i,
  input wire logic ref_write_i,
  input wire logic ref_instr_i,
  input wire logic [1:0] ref_size_i,
  input wire logic supervisor_i,
  input wire logic [ADDR_W-1:0] limit_lo_i,
  input wire logic [ADDR_W-1:0] limit_hi_i,
  output logic [3:0] cause_o
);
  logic misaligned;
  logic low_ref;
  logic out_of_bounds;

  // Instructions need halfword boundaries; operands follow their size
  always_comb begin
    misaligned = 1'b0;
    if (ref_instr_i || ref_size_i == SZ_HALF) begin
      misaligned = ref_addr_i[0]; // RULE_08
    end else if (ref_size_i == SZ_FULL) begin
      misaligned = |ref_addr_i[1:0]; // RULE_08
    end
  end

  assign low_ref = ref_addr_i < LOW_STORE_BYTES; // RULE_06
  assign out_of_bounds = ref_addr_i < limit_lo_i || ref_addr_i > limit_hi_i;

  // One cause is reported; protection outranks addressing and alignment
  always_comb begin
    cause_o = PX_NONE;
    if (ref_valid_i) begin
      if (ref_write_i && out_of_bounds) begin
        cause_o = PX_PROTECT; // RULE_04
      end else if (!supervisor_i && low_ref) begin
        cause_o = PX_ADDRESS; // RULE_05
      end else if (misaligned) begin
        cause_o = PX_SPEC; // RULE_07
      end
    end
  end
endmodule : ipsc_access_chk
`default_nettype wire

// ===== hdl/ipsc_core.sv
// Interrupt priority and processor state control.
// Assumes the execution logic presents events with the same clock and
// marks instruction boundaries; channel requests arrive from pins.
// Operation
// RULE_01: Seven classes ranked in fixed priority order.
// RULE_02: Supervisor call raises interrupt, stores parameter link.
// RULE_03: Illegal or privileged-in-problem opcode raises program interrupt.
// RULE_04: Write outside limits raises protection exception.
// RULE_05: Problem-state low storage reference raises addressing exception.
// RULE_06: Low storage is the lowest 512 bytes.
// RULE_07: Misaligned operand or instruction raises specification exception.
// RULE_08: Halfwords on two, fullwords on four bytes.
// RULE_09: Binary or decimal overflow raises program interrupt.
// RULE_10: Timer reaching zero raises timer interrupt.
// RULE_11: Each selector channel has its own request.
// RULE_12: Shared subchannel status goes to its control word.
// RULE_13: Nonshared interrupt tables its source and cause.
// RULE_14: Eight shared, up to 128 nonshared subchannels.
// RULE_15: Any interrupt enters supervisor state.
// RULE_16: Supervisor state allows privileged, supervisor registers, low storage.
// RULE_17: Problem state forbids privileged, problem registers, low storage.
// RULE_18: Two sets of sixteen 32-bit general registers.
// RULE_19: Highest priority first, only at instruction boundaries.
`timescale 1ns/1ps
`default_nettype none
module ipsc_core
  import ipsc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Execution side events
  input wire logic boundary_i,
  input wire logic svc_exec_i,
  input wire logic [7:0] svc_code_i,
  input wire logic [ADDR_W-1:0] svc_link_i,
  input wire logic op_valid_i,
  input wire logic op_illegal_i,
  input wire logic op_privileged_i,
  input wire logic bin_ovf_i,
  input wire logic dec_ovf_i,
  input wire logic timer_dec_i,
  input wire logic [GREG_W-1:0] timer_value_i,
  input wire logic ref_valid_i,
  input wire logic [ADDR_W-1:0] ref_addr_i,
  input wire logic ref_write_i,
  input wire logic ref_instr_i,
  input wire logic [1:0] ref_size_i,
  input wire logic limits_load_i,
  input wire logic [ADDR_W-1:0] limits_lo_i,
  input wire logic [ADDR_W-1:0] limits_hi_i,
  input wire logic return_problem_i,
  // Channel side requests, from pins
  input wire logic sel1_req_i,
  input wire logic sel2_req_i,
  input wire logic muxsh_req_i,
  input wire logic [2:0] muxsh_sub_i,
  input wire logic [7:0] muxsh_status_i,
  input wire logic muxns_req_i,
  input wire logic [6:0] muxns_line_i,
  input wire logic [7:0] muxns_cause_i,
  input wire logic comm_option_i,
  input wire logic ack_i,
  // Outputs to execution logic and channels
  output logic supervisor_o,
  output logic priv_allowed_o,
  output logic low_store_ok_o,
  output logic greg_set_o,
  output logic [ADDR_W-1:0] greg_base_o,
  output logic ref_fault_o,
  output logic int_valid_o,
  output logic [2:0] int_class_o,
  output logic [3:0] int_cause_o,
  output logic [ADDR_W-1:0] int_link_o,
  output logic [7:0] int_code_o,
  output logic sel1_ack_o,
  output logic sel2_ack_o,
  output logic scw_we_o,
  output logic [2:0] scw_sub_o,
  output logic [7:0] scw_status_o,
  output logic tbl_we_o,
  output logic [6:0] tbl_line_o,
  output logic [7:0] tbl_cause_o
);
  ipsc_state_t state;
  logic supervisor;
  logic [ADDR_W-1:0] limit_lo;
  logic [ADDR_W-1:0] limit_hi;
  logic [NUM_CLASSES-1:0] pend;
  logic [NUM_CLASSES-1:0] set_req;
  logic [NUM_CLASSES-1:0] clr_req;
  logic [3:0] prog_cause;
  logic [3:0] next_prog_cause;
  logic [3:0] ref_cause;
  logic [ADDR_W-1:0] svc_link;
  logic [7:0] svc_code;
  logic [2:0] sh_sub;
  logic [7:0] sh_status;
  logic [6:0] ns_line;
  logic [7:0] ns_cause;
  logic [2:0] win_class;
  logic win_any;
  logic [2:0] sync1 [0:3];
  logic [3:0] chan_lvl;
  logic [3:0] chan_prev;
  logic [3:0] chan_rise;
  logic timer_hit;

  // Pin requests pass three stages; a level counts once stages 2 and 3 agree
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      logic raw;
      if (g == 0) begin : g_s1
        assign raw = sel1_req_i;
      end else if (g == 1) begin : g_s2
        assign raw = sel2_req_i;
      end else if (g == 2) begin : g_sh
        assign raw = muxsh_req_i;
      end else begin : g_ns
        assign raw = muxns_req_i & comm_option_i; // RULE_14
      end
      always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
          sync1[g] <= 3'h0;
          chan_lvl[g] <= 1'b0;
        end else begin
          sync1[g] <= {sync1[g][1:0], raw};
          if (sync1[g][1] == sync1[g][2]) begin
            chan_lvl[g] <= sync1[g][2];
          end
        end
      end
    end
  endgenerate

  // Requests are edge events so a held line is not taken twice
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      chan_prev <= 4'h0;
    end else begin
      chan_prev <= chan_lvl;
    end
  end
  assign chan_rise = chan_lvl & ~chan_prev;

  // Reference checks against limits and processor state
  ipsc_access_chk u_chk (
    .ref_valid_i(ref_valid_i),
    .ref_addr_i(ref_addr_i),
    .ref_write_i(ref_write_i),
    .ref_instr_i(ref_instr_i),
    .ref_size_i(ref_size_i),
    .supervisor_i(supervisor),
    .limit_lo_i(limit_lo),
    .limit_hi_i(limit_hi),
    .cause_o(ref_cause)
  );

  // Timer fires when a decrement step leaves the stored value at zero
  assign timer_hit = timer_dec_i && timer_value_i == '0; // RULE_10

  // First program exception cause in this instruction
  always_comb begin
    next_prog_cause = PX_NONE;
    if (op_valid_i && op_illegal_i) begin
      next_prog_cause = PX_ILLEGAL_OP; // RULE_03
    end else if (op_valid_i && op_privileged_i && !supervisor) begin
      next_prog_cause = PX_PRIVILEGED; // RULE_03 RULE_17
    end else if (ref_cause != PX_NONE) begin
      next_prog_cause = ref_cause;
    end else if (bin_ovf_i) begin
      next_prog_cause = PX_BIN_OVF; // RULE_09
    end else if (dec_ovf_i) begin
      next_prog_cause = PX_DEC_OVF; // RULE_09
    end
  end

  // Raw set terms for each class, kept apart per channel
  always_comb begin
    set_req = '0;
    set_req[CLS_SVC] = svc_exec_i; // RULE_02
    set_req[CLS_PROG] = next_prog_cause != PX_NONE;
    set_req[CLS_TIMER] = timer_hit;
    set_req[CLS_SEL1] = chan_rise[0]; // RULE_11
    set_req[CLS_SEL2] = chan_rise[1]; // RULE_11
    set_req[CLS_MUXSH] = chan_rise[2];
    set_req[CLS_MUXNS] = chan_rise[3];
  end

  // Pending flags; a new event wins over the clear of the same cycle
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      pend <= '0;
    end else begin
      pend <= (pend & ~clr_req) | set_req;
    end
  end

  // Capture program cause; the first one in a pending window is kept
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      prog_cause <= PX_NONE;
    end else if (set_req[CLS_PROG] && (!pend[CLS_PROG] || clr_req[CLS_PROG])) begin
      prog_cause <= next_prog_cause;
    end
  end

  // Status payloads per class, reloaded by each new event of that class
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      svc_link <= '0;
      svc_code <= 8'h00;
      sh_sub <= 3'h0;
      sh_status <= 8'h00;
      ns_line <= 7'h00;
      ns_cause <= 8'h00;
    end else begin
      if (svc_exec_i) begin
        svc_link <= svc_link_i; // RULE_02
        svc_code <= svc_code_i;
      end
      if (chan_rise[2]) begin
        sh_sub <= muxsh_sub_i; // RULE_14
        sh_status <= muxsh_status_i;
      end
      if (chan_rise[3]) begin
        ns_line <= muxns_line_i; // RULE_14
        ns_cause <= muxns_cause_i;
      end
    end
  end

  ipsc_prio_enc u_prio (
    .req_i(pend),
    .sel_o(win_class),
    .any_o(win_any)
  );

  // Take one interrupt per boundary and hold it until acknowledged
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      state <= IPSC_RUN;
    end else begin
      case (state)
        IPSC_RUN: begin
          if (win_any && boundary_i) begin
            state <= IPSC_TAKE; // RULE_19
          end
        end
        IPSC_TAKE: state <= IPSC_WAIT;
        IPSC_WAIT: begin
          if (ack_i) begin
            state <= IPSC_RUN;
          end
        end
        default: state <= IPSC_RUN;
      endcase
    end
  end

  // Latch the winning class and its status when the interrupt is taken
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      int_class_o <= CLS_NONE;
      int_cause_o <= PX_NONE;
      int_link_o <= '0;
      int_code_o <= 8'h00;
    end else if (state == IPSC_RUN && win_any && boundary_i) begin
      int_class_o <= win_class; // RULE_19
      int_cause_o <= win_class == CLS_PROG ? prog_cause : PX_NONE;
      int_link_o <= win_class == CLS_SVC ? svc_link : '0;
      int_code_o <= win_class == CLS_SVC ? svc_code : 8'h00;
    end
  end

  // Clear the taken flag in the same edge that latches it
  always_comb begin
    clr_req = '0;
    if (state == IPSC_RUN && win_any && boundary_i) begin
      clr_req[win_class] = 1'b1;
    end
  end

  // Processor state; entering supervisor on take outranks a return request
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      supervisor <= RST_SUPERVISOR;
    end else if (state == IPSC_RUN && win_any && boundary_i) begin
      supervisor <= 1'b1; // RULE_15
    end else if (return_problem_i && supervisor && state == IPSC_RUN) begin
      supervisor <= 1'b0;
    end
  end

  // Bounds are only loadable by the supervisor
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      limit_lo <= RST_LIMIT_LO;
      limit_hi <= RST_LIMIT_HI;
    end else if (limits_load_i && supervisor) begin
      limit_lo <= limits_lo_i; // RULE_04
      limit_hi <= limits_hi_i;
    end
  end

  // One-cycle status writes to control word and nonshared table
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      scw_we_o <= 1'b0;
      scw_sub_o <= 3'h0;
      scw_status_o <= 8'h00;
      tbl_we_o <= 1'b0;
      tbl_line_o <= 7'h00;
      tbl_cause_o <= 8'h00;
    end else begin
      scw_we_o <= state == IPSC_RUN && win_any && boundary_i && win_class == CLS_MUXSH;
      tbl_we_o <= state == IPSC_RUN && win_any && boundary_i && win_class == CLS_MUXNS;
      if (state == IPSC_RUN && win_any && boundary_i && win_class == CLS_MUXSH) begin
        scw_sub_o <= sh_sub; // RULE_12
        scw_status_o <= sh_status; // RULE_12
      end
      if (state == IPSC_RUN && win_any && boundary_i && win_class == CLS_MUXNS) begin
        tbl_line_o <= ns_line; // RULE_13
        tbl_cause_o <= ns_cause; // RULE_13
      end
    end
  end

  // Register set select; each set is sixteen words at its own base
  assign supervisor_o = supervisor;
  assign priv_allowed_o = supervisor; // RULE_16 RULE_17
  assign low_store_ok_o = supervisor; // RULE_16 RULE_17
  assign greg_set_o = supervisor; // RULE_16
  assign greg_base_o = supervisor ? ADDR_W'(0) : ADDR_W'(NUM_GREGS * GREG_W / 8); // RULE_18
  assign ref_fault_o = ref_cause != PX_NONE;
  assign int_valid_o = state == IPSC_WAIT;
  assign sel1_ack_o = state == IPSC_WAIT && int_class_o == CLS_SEL1;
  assign sel2_ack_o = state == IPSC_WAIT && int_class_o == CLS_SEL2;
endmodule : ipsc_core
`default_nettype wire

// ===== hdl/ipsc_pkg.sv
// Package for the interrupt priority and processor state control block.
// Assumes one processor clock and byte addresses on the storage reference port.
package ipsc_pkg;
  // Interrupt classes, index 0 is the highest priority
  localparam int NUM_CLASSES = 7;
  localparam logic [2:0] CLS_SVC = 3'h0;
  localparam logic [2:0] CLS_PROG = 3'h1;
  localparam logic [2:0] CLS_TIMER = 3'h2;
  localparam logic [2:0] CLS_SEL1 = 3'h3;
  localparam logic [2:0] CLS_SEL2 = 3'h4;
  localparam logic [2:0] CLS_MUXSH = 3'h5;
  localparam logic [2:0] CLS_MUXNS = 3'h6;
  localparam logic [2:0] CLS_NONE = 3'h7;

  // Storage geometry
  localparam int ADDR_W = 24;
  localparam logic [23:0] LOW_STORE_BYTES = 24'h000200;
  localparam int HALF_ALIGN = 2;
  localparam int FULL_ALIGN = 4;
  localparam int NUM_GREGS = 16;
  localparam int GREG_W = 32;

  // Multiplexer subchannels
  localparam int NUM_SHARED = 8;
  localparam int NUM_NONSHARED = 128;

  // Program exception cause codes
  localparam logic [3:0] PX_NONE = 4'h0;
  localparam logic [3:0] PX_ILLEGAL_OP = 4'h1;
  localparam logic [3:0] PX_PRIVILEGED = 4'h2;
  localparam logic [3:0] PX_PROTECT = 4'h3;
  localparam logic [3:0] PX_ADDRESS = 4'h4;
  localparam logic [3:0] PX_SPEC = 4'h5;
  localparam logic [3:0] PX_BIN_OVF = 4'h6;
  localparam logic [3:0] PX_DEC_OVF = 4'h7;

  // Operand size codes on the storage reference port
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_FULL = 2'h2;

  // Reset values
  localparam logic RST_SUPERVISOR = 1'b1;
  localparam logic [ADDR_W-1:0] RST_LIMIT_LO = 24'h000000;
  localparam logic [ADDR_W-1:0] RST_LIMIT_HI = 24'hffffff;

  typedef enum logic [1:0] {
    IPSC_RUN,
    IPSC_TAKE,
    IPSC_WAIT
  } ipsc_state_t;
endpackage : ipsc_pkg

// ===== hdl/ipsc_prio_enc.sv
// Fixed priority encoder over the interrupt classes.
// Assumes request bit 0 is the highest priority class.
`timescale 1ns/1ps
`default_nettype none
module ipsc_prio_enc
  import ipsc_pkg::*;
(
  input wire logic [NUM_CLASSES-1:0] req_i,
  output logic [2:0] sel_o,
  output logic any_o
);
  // Scan from lowest priority upward so the highest pending wins
  always_comb begin
    sel_o = CLS_NONE;
    for (int i = NUM_CLASSES - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        sel_o = 3'(i); // RULE_01
      end
    end
    any_o = |req_i;
  end
endmodule : ipsc_prio_enc
`default_nettype wire

// ===== tb/ipsc_core_props.sv
// Checker for the interrupt priority and processor state block.
// Assumes it is bound to ipsc_core and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module ipsc_core_props
  import ipsc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic boundary_i,
  input wire logic ack_i,
  input wire logic ref_valid_i,
  input wire logic [ADDR_W-1:0] ref_addr_i,
  input wire logic [1:0] ref_size_i,
  input wire logic supervisor_o,
  input wire logic priv_allowed_o,
  input wire logic low_store_ok_o,
  input wire logic [ADDR_W-1:0] greg_base_o,
  input wire logic ref_fault_o,
  input wire logic int_valid_o,
  input wire logic [2:0] int_class_o,
  input wire logic sel1_ack_o,
  input wire logic sel2_ack_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  // Steps of one presented interrupt
  sequence s_held;
    int_valid_o && !ack_i;
  endsequence
  sequence s_taken;
    int_valid_o && ack_i;
  endsequence

  a_valid_stands:
    assert property (s_held |=> int_valid_o && $stable(int_class_o))
    else $error("interrupt withdrawn before acknowledge");
  a_ack_clears:
    assert property (s_taken |=> !int_valid_o)
    else $error("interrupt still presented after acknowledge");
  a_take_super:
    assert property ($rose(int_valid_o) |-> supervisor_o)
    else $error("interrupt presented outside supervisor state");
  a_take_boundary:
    assert property ($rose(supervisor_o) |-> $past(boundary_i))
    else $error("state switched away from an instruction boundary");
  a_mode_outputs:
    assert property (priv_allowed_o == supervisor_o && low_store_ok_o == supervisor_o)
    else $error("mode outputs disagree with state");
  a_greg_base:
    assert property (greg_base_o == (supervisor_o ? 24'h000000 : 24'h000040))
    else $error("register set base wrong for state");
  a_low_fault:
    assert property (ref_valid_i && !supervisor_o && ref_addr_i < LOW_STORE_BYTES |-> ref_fault_o)
    else $error("low storage reference not refused");
  a_align_fault:
    assert property (ref_valid_i && ((ref_size_i == SZ_HALF && ref_addr_i[0])
      || (ref_size_i == SZ_FULL && ref_addr_i[1:0] != 2'h0)) |-> ref_fault_o)
    else $error("misaligned reference not refused");
  a_chan_ack:
    assert property (sel1_ack_o == (int_valid_o && int_class_o == CLS_SEL1)
      && sel2_ack_o == (int_valid_o && int_class_o == CLS_SEL2))
    else $error("selector acknowledge mixed up");
endmodule : ipsc_core_props

bind ipsc_core ipsc_core_props u_props (
  .core_clk_i(core_clk_i),
  .nrst_i(nrst_i),
  .boundary_i(boundary_i),
  .ack_i(ack_i),
  .ref_valid_i(ref_valid_i),
  .ref_addr_i(ref_addr_i),
  .ref_size_i(ref_size_i),
  .supervisor_o(supervisor_o),
  .priv_allowed_o(priv_allowed_o),
  .low_store_ok_o(low_store_ok_o),
  .greg_base_o(greg_base_o),
  .ref_fault_o(ref_fault_o),
  .int_valid_o(int_valid_o),
  .int_class_o(int_class_o),
  .sel1_ack_o(sel1_ack_o),
  .sel2_ack_o(sel2_ack_o)
);
`default_nettype wire

// ===== tb/ipsc_far_model.sv
// Far-side model: channel request pins with their payload, and the execution ack.
// Assumes the bench asks for requests by raising fire_i for one clock.
`timescale 1ns/1ps
`default_nettype none
module ipsc_far_model (
  input wire logic clk_i,
  input wire logic [3:0] fire_i,
  input wire logic [6:0] src_i,
  input wire logic [7:0] code_i,
  input wire logic [3:0] ack_dly_i,
  input wire logic int_valid_i,
  output logic [3:0] req_o,
  output logic [2:0] muxsh_sub_o,
  output logic [7:0] muxsh_status_o,
  output logic [6:0] muxns_line_o,
  output logic [7:0] muxns_cause_o,
  output logic ack_o
);
  logic [3:0] hold;
  logic [3:0] wait_cnt;

  initial begin
    {req_o, muxsh_sub_o, muxsh_status_o, muxns_line_o, muxns_cause_o, ack_o} = '0;
    hold = 4'h0;
    wait_cnt = 4'h0;
  end

  // Each channel owns its pin; payload turns over once its hold runs out,
  // so a late sample by the block cannot pass for a good one
  always @(posedge clk_i) begin
    if (|fire_i) begin
      req_o <= fire_i;
      {muxsh_sub_o, muxsh_status_o} <= {src_i[2:0], code_i};
      {muxns_line_o, muxns_cause_o} <= {src_i, code_i};
      hold <= 4'h8;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
      if (hold == 4'h1) begin
        req_o <= 4'h0;
        {muxsh_sub_o, muxsh_status_o} <= ~{muxsh_sub_o, muxsh_status_o};
        {muxns_line_o, muxns_cause_o} <= ~{muxns_line_o, muxns_cause_o};
      end
    end
  end

  // Accept a presented interrupt after ack_dly_i cycles, prompt or slow
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    if (!int_valid_i || ack_o) begin
      wait_cnt <= 4'h0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt == ack_dly_i) ack_o <= 1'b1;
    end
  end
endmodule : ipsc_far_model
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for ipsc_core with the far-side model.
// Assumes the package, design and bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ipsc_pkg::*;
  logic core_clk_i, nrst_i, boundary_i, svc_exec_i, op_valid_i, op_illegal_i, op_privileged_i;
  logic bin_ovf_i, dec_ovf_i, timer_dec_i, ref_valid_i, ref_write_i, ref_instr_i;
  logic limits_load_i, return_problem_i, comm_option_i, ack_i;
  logic sel1_req_i, sel2_req_i, muxsh_req_i, muxns_req_i;
  logic [7:0] svc_code_i, muxsh_status_i, muxns_cause_i, int_code_o, scw_status_o, tbl_cause_o;
  logic [ADDR_W-1:0] svc_link_i, ref_addr_i, limits_lo_i, limits_hi_i, greg_base_o, int_link_o;
  logic [GREG_W-1:0] timer_value_i;
  logic [1:0] ref_size_i;
  logic [2:0] muxsh_sub_i, int_class_o, scw_sub_o;
  logic [6:0] muxns_line_i, tbl_line_o, src;
  logic [3:0] int_cause_o, fire, ack_dly;
  logic supervisor_o, priv_allowed_o, low_store_ok_o, greg_set_o, ref_fault_o, int_valid_o;
  logic sel1_ack_o, sel2_ack_o, scw_we_o, tbl_we_o;
  logic [7:0] code;
  logic [10:0] seen_scw;
  logic [14:0] seen_tbl;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  ipsc_core dut (.*);
  ipsc_far_model u_far (.clk_i(core_clk_i), .fire_i(fire), .src_i(src), .code_i(code),
    .ack_dly_i(ack_dly), .int_valid_i(int_valid_o),
    .req_o({muxns_req_i, muxsh_req_i, sel2_req_i, sel1_req_i}), .muxsh_sub_o(muxsh_sub_i),
    .muxsh_status_o(muxsh_status_i), .muxns_line_o(muxns_line_i),
    .muxns_cause_o(muxns_cause_i), .ack_o(ack_i));

  // Status writes last one cycle, so catch them here; also cut a hang short
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (scw_we_o) seen_scw <= {scw_sub_o, scw_status_o};
    if (tbl_we_o) seen_tbl <= {tbl_line_o, tbl_cause_o};
    if (cycles == 20000) begin
      fail_count++;
      print_verdict;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : tick

  task automatic clear_events;
    {svc_exec_i, op_valid_i, op_illegal_i, op_privileged_i, bin_ovf_i, dec_ovf_i} = '0;
    {timer_dec_i, limits_load_i, return_problem_i, fire} = '0;
  endtask : clear_events

  // Hand the block back to a problem program
  task automatic to_problem;
    tick(1);
    return_problem_i = 1'b1;
    tick(1);
    return_problem_i = 1'b0;
    tick(2);
  endtask : to_problem

  // Open a boundary, expect one interrupt of this class, then let it be accepted
  task automatic take(input logic [2:0] cls, input logic [3:0] cause);
    int n;
    n = 0;
    boundary_i = 1'b1;
    while (int_valid_o !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    boundary_i = 1'b0;
    check("class", int_class_o, cls);
    check("supervisor", supervisor_o, 1'b1);
    if (cls == CLS_PROG) check("cause", int_cause_o, cause);
    if (cls == CLS_SVC) check("link", int_link_o, svc_link_i);
    if (cls == CLS_SVC) check("code", int_code_o, svc_code_i);
    while (int_valid_o === 1'b1 && n < 120) begin
      tick(1);
      n++;
    end
  endtask : take

  task automatic t_state;
    check("reset state", {supervisor_o, int_valid_o, greg_base_o}, 26'h2000000);
    to_problem;
    check("problem mode", {priv_allowed_o, low_store_ok_o, greg_set_o}, 3'h0);
    check("problem base", greg_base_o, 24'h000040);
  endtask : t_state

  // Every class pending at once must come out in fixed order, one per boundary
  task automatic t_priority;
    to_problem;
    {comm_option_i, src, code} = {1'b1, 7'h55, 8'ha6};
    {svc_code_i, svc_link_i} = {8'h3c, 24'h012344};
    {svc_exec_i, op_valid_i, op_illegal_i, timer_dec_i, fire} = {4'hf, 4'hf};
    timer_value_i = 32'h00000000;
    tick(1);
    clear_events;
    tick(8);
    for (int c = 0; c < NUM_CLASSES; c++) take(3'(c), PX_ILLEGAL_OP);
    check("shared status", seen_scw, {3'h5, 8'ha6});
    check("nonshared entry", seen_tbl, {7'h55, 8'ha6});
  endtask : t_priority

  // Each opcode and overflow program cause alone, then events that must stay quiet
  task automatic t_prog;
    logic [3:0] exp [4] = '{PX_ILLEGAL_OP, PX_PRIVILEGED, PX_BIN_OVF, PX_DEC_OVF};
    for (int i = 0; i < 4; i++) begin
      to_problem;
      {op_valid_i, op_illegal_i, op_privileged_i} = {i < 2, i == 0, i == 1};
      {bin_ovf_i, dec_ovf_i} = {i == 2, i == 3};
      tick(1);
      clear_events;
      take(CLS_PROG, exp[i]);
    end
    {op_valid_i, op_privileged_i, timer_dec_i, comm_option_i} = 4'he;
    {timer_value_i, fire} = {32'h00000001, 4'h8};
    tick(1);
    clear_events;
    tick(8);
    // The model accepts within a few cycles, so look at every boundary cycle
    boundary_i = 1'b1;
    repeat (6) begin
      tick(1);
      check("quiet", int_valid_o, 1'b0);
    end
    boundary_i = 1'b0;
  endtask : t_prog

  // Reference checks against limits, low storage and alignment
  task automatic t_ref;
    logic [ADDR_W-1:0] adr [8] = '{24'h0001ff, 24'h000200, 24'h001001, 24'h001002,
      24'h001002, 24'h002000, 24'h001800, 24'h002000};
    logic [3:0] knd [8] = '{4'h8, 4'h0, 4'h9, 4'h1, 4'ha, 4'hc, 4'h6, 4'h0};
    {limits_load_i, limits_lo_i, limits_hi_i} = {1'b1, 24'h001000, 24'h001fff};
    {ref_valid_i, ref_addr_i, ref_size_i} = {1'b1, 24'h0001ff, SZ_BYTE};
    tick(1);
    check("super low ref", ref_fault_o, 1'b0);
    {limits_load_i, ref_valid_i} = 2'h0;
    to_problem;
    // A load from a problem program must leave the bounds alone
    {limits_load_i, limits_lo_i, limits_hi_i} = {1'b1, 24'h000000, 24'hffffff};
    tick(1);
    {limits_load_i, ref_valid_i} = 2'h1;
    for (int i = 0; i < 8; i++) begin
      {ref_addr_i, ref_write_i, ref_size_i} = {adr[i], knd[i][2:0]};
      #1;
      check("ref fault", ref_fault_o, knd[i][3]);
      tick(1);
    end
    // Instruction fetches need halfword boundaries whatever the size code
    {ref_instr_i, ref_addr_i, ref_size_i} = {1'b1, 24'h001001, SZ_BYTE};
    #1;
    check("instr fault", ref_fault_o, 1'b1);
    tick(1);
    {ref_valid_i, ref_instr_i} = 2'h0;
    ack_dly = 4'hf;
    take(CLS_PROG, PX_ADDRESS);
    ack_dly = 4'h0;
  endtask : t_ref

  initial begin
    {nrst_i, boundary_i, ref_valid_i, ref_write_i, ref_instr_i, comm_option_i} = '0;
    {svc_code_i, svc_link_i, timer_value_i, ref_addr_i, ref_size_i} = '0;
    {limits_lo_i, limits_hi_i, src, code, ack_dly} = '0;
    clear_events;
    tick(16);
    nrst_i = 1'b1;
    tick(1);
    t_state;
    t_priority;
    t_prog;
    t_ref;
    print_verdict;
  end
endmodule : tb_top
`default_nettype wire
